/* File: include/rxsw_pkg.sv */
// Package for the receive status write-back engine: constants and carrier types
package rxsw_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] RXSW_CTRL_OFS   = 8'h00;
  localparam logic [7:0] RXSW_STAT_OFS   = 8'h04;
  localparam logic [7:0] RXSW_LAST_OFS   = 8'h08;
  localparam logic [7:0] RXSW_WDOG_OFS   = 8'h0c;
  localparam logic [7:0] RXSW_FRAMES_OFS = 8'h10;

  // Control register field positions
  localparam int RXSW_CTRL_TS_BIT     = 0;
  localparam int RXSW_CTRL_CSUM1_BIT  = 1;
  localparam int RXSW_CTRL_JUMBO_BIT  = 2;
  localparam int RXSW_CTRL_HDX_BIT    = 3;
  localparam int RXSW_CTRL_GIANT2K_BIT = 27;
  localparam logic [31:0] RXSW_CTRL_RST = 32'h0000_0000;
  localparam logic [13:0] RXSW_WDOG_RST = 14'h0800;

  // ****************************************************
  // Status word field positions
  // ****************************************************
  localparam int RXSW_OWN_BIT  = 31;
  localparam int RXSW_FL_LSB   = 16;
  localparam int RXSW_ES_BIT   = 15;
  localparam int RXSW_OE_BIT   = 11;
  localparam int RXSW_VLAN_BIT = 10;
  localparam int RXSW_FS_BIT   = 9;
  localparam int RXSW_LS_BIT   = 8;
  localparam int RXSW_MP_BIT   = 7;
  localparam int RXSW_LC_BIT   = 6;
  localparam int RXSW_FT_BIT   = 5;
  localparam int RXSW_RWT_BIT  = 4;
  localparam int RXSW_RE_BIT   = 3;
  localparam int RXSW_CE_BIT   = 1;

  // Descriptor word indices written back
  localparam logic [2:0] RXSW_WORD_STATUS = 3'h0;
  localparam logic [2:0] RXSW_WORD_TS_LO  = 3'h6;
  localparam logic [2:0] RXSW_WORD_TS_HI  = 3'h7;

  // ****************************************************
  // Frame limits
  // ****************************************************
  localparam logic [13:0] RXSW_GIANT_STD   = 14'd1518;
  localparam logic [13:0] RXSW_GIANT_VLAN  = 14'd1522;
  localparam logic [13:0] RXSW_GIANT_2K    = 14'd2000;
  localparam logic [13:0] RXSW_JUMBO_STD   = 14'd9018;
  localparam logic [13:0] RXSW_JUMBO_VLAN  = 14'd9022;
  localparam logic [15:0] RXSW_ETHTYPE_MIN = 16'd1536;
  localparam logic [13:0] RXSW_LT_HI_IDX   = 14'd12;
  localparam logic [13:0] RXSW_LT_LO_IDX   = 14'd13;

  // ****************************************************
  // Carrier types
  // ****************************************************
  typedef struct packed {
    logic [12:0] buf1_size;
    logic [12:0] buf2_size;
    logic        chained;
  } rxsw_desc_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rxsw_beat_t;

  typedef struct packed {
    logic        crc_err;
    logic        overflow;
    logic        late_col;
    logic        vlan;
    logic        ipv4;
    logic        csum_err;
    logic        ip_err;
    logic        ts_valid;
    logic [63:0] ts;
  } rxsw_info_t;

  typedef struct packed {
    logic [2:0]  word;
    logic [31:0] data;
  } rxsw_wb_t;

  typedef enum logic [2:0] {
    RXSW_IDLE    = 3'b000,
    RXSW_FETCH   = 3'b001,
    RXSW_RECV    = 3'b011,
    RXSW_WB_TS   = 3'b010,
    RXSW_WB_STAT = 3'b110,
    RXSW_WB_OWN  = 3'b111,
    RXSW_DROP    = 3'b101
  } rxsw_state_t;

endpackage

/* File: src/rxsw_engine.sv */
// Receive status write-back engine: segments frames over descriptors and writes status
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Overflow bit set on FIFO overflow damage
// - VLAN bit set for recognised tagged frames
// - First-segment bit in descriptor holding frame start
// - Zero buffer sizes push start onward
// - Last-segment bit in descriptor holding frame end
// - Multi-purpose bit flags a valid timestamp, stored unless the last beat meets the watchdog limit
// - Timestamp meaning only in last descriptor
// - Checksum mode: flag IPv4 header checksum mismatch
// - Checksum mode: flag non-IPv4 frames too
// - Otherwise flag giant frames, 1518/1522 limit
// - Config bit 27 raises giant limit to 2000
// - Jumbo mode limit 9018/9022 bytes
// - Late collision bit in half-duplex reception
// - Frame-type set when length/type >= 1536
// - Frame-type clear for length-encoded frames
// - Frame-type meaningless for runts under 14 bytes
// - Watchdog expiry sets watchdog-timeout bit
// - Watchdog expiry truncates the frame
// - Receive-error bit on error during data-valid
// - Owner bit cleared at completion or full
// - Error summary ORs errors, last descriptor only
module rxsw_engine (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Descriptor supply
  input  wire logic                desc_valid_i,
  input  wire rxsw_pkg::rxsw_desc_t desc_i,
  output logic                     desc_ready_o,
  // Receive byte stream
  input  wire logic                rx_valid_i,
  input  wire rxsw_pkg::rxsw_beat_t rx_beat_i,
  input  wire rxsw_pkg::rxsw_info_t rx_info_i,
  input  wire logic                rx_dv_i,
  input  wire logic                rx_er_i,
  output logic                     rx_ready_o,
  // Descriptor write-back
  output logic                     wb_valid_o,
  output rxsw_pkg::rxsw_wb_t       wb_o,
  input  wire logic                wb_ready_i
);
  import rxsw_pkg::*;

  rxsw_state_t state_q;
  logic [31:0] ctrl_q;
  logic [13:0] wdog_q;
  logic [31:0] last_q;
  logic [15:0] frames_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        desc_ready_q;
  logic        rx_ready_q;
  logic        wb_valid_q;
  rxsw_wb_t    wb_q;
  logic [13:0] room_q;
  logic [13:0] flen_q;
  logic        in_frame_q;
  logic        fs_q;
  logic        ls_q;
  logic        re_q;
  logic        rwt_q;
  logic [15:0] lt_q;
  rxsw_info_t  info_q;
  logic        ts_hi_q;
  logic [31:0] stat_q;

  logic        take;
  logic        fin;
  logic        full;
  logic        wdog_hit;
  logic [13:0] cap;
  logic [13:0] giant_lim;
  logic        giant;
  logic        mp_bit;
  logic        ft_bit;
  logic        es_bit;
  logic [31:0] stat_d;
  logic        apb_wr;
  logic        apb_setup;

  // ****************************************************
  // APB slave
  // ****************************************************
  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr    = psel_i & penable_i & pwrite_i & pready_q;

  // Answer in the first access cycle: ready is raised by the setup cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (apb_setup) begin
        unique case (paddr_i)
          RXSW_CTRL_OFS:   prdata_q <= ctrl_q;
          RXSW_STAT_OFS:   prdata_q <= {25'h0, in_frame_q, 3'h0, state_q};
          RXSW_LAST_OFS:   prdata_q <= last_q;
          RXSW_WDOG_OFS:   prdata_q <= {18'h0, wdog_q};
          RXSW_FRAMES_OFS: prdata_q <= {16'h0, frames_q};
          default:         pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Software writes steer the giant/checksum/timestamp and watchdog logic
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= RXSW_CTRL_RST;
      wdog_q <= RXSW_WDOG_RST;
    end else if (apb_wr) begin
      if (paddr_i == RXSW_CTRL_OFS) ctrl_q <= pwdata_i;
      if (paddr_i == RXSW_WDOG_OFS) wdog_q <= pwdata_i[13:0];
    end
  end

  // ****************************************************
  // Segmentation and status composition
  // ****************************************************
  assign take     = rx_valid_i & rx_ready_q;
  // Chained descriptor carries no second buffer
  assign cap      = {1'b0, desc_i.buf1_size} +
                    (desc_i.chained ? 14'h0000 : {1'b0, desc_i.buf2_size});
  assign wdog_hit = take & ((flen_q + 14'd1) >= wdog_q);
  assign fin      = take & (rx_beat_i.last | wdog_hit);
  assign full     = take & (room_q == 14'd1);

  // Giant limit selection
  always_comb begin
    if (ctrl_q[RXSW_CTRL_JUMBO_BIT]) begin
      giant_lim = info_q.vlan ? RXSW_JUMBO_VLAN : RXSW_JUMBO_STD;
    end else if (ctrl_q[RXSW_CTRL_GIANT2K_BIT]) begin
      giant_lim = RXSW_GIANT_2K;
    end else begin
      giant_lim = info_q.vlan ? RXSW_GIANT_VLAN : RXSW_GIANT_STD;
    end
  end
  assign giant = flen_q > giant_lim;

  // Multi-purpose bit meaning depends on the configured feature set
  always_comb begin
    if (ctrl_q[RXSW_CTRL_TS_BIT]) begin
      mp_bit = info_q.ts_valid;
    end else if (ctrl_q[RXSW_CTRL_CSUM1_BIT]) begin
      mp_bit = ~info_q.ipv4 | info_q.csum_err;
    end else begin
      mp_bit = giant;
    end
  end

  // Runts never capture a full length/type field, so the bit reads clear
  assign ft_bit = (flen_q > RXSW_LT_LO_IDX) & (lt_q >= RXSW_ETHTYPE_MIN);
  assign es_bit = info_q.crc_err | re_q | rwt_q |
                  (info_q.late_col & ctrl_q[RXSW_CTRL_HDX_BIT]) |
                  (giant & ~ctrl_q[RXSW_CTRL_TS_BIT] & ~ctrl_q[RXSW_CTRL_CSUM1_BIT]) |
                  info_q.ip_err | info_q.overflow;

  // Error and frame bits only land in the last descriptor
  always_comb begin
    stat_d               = 32'h0000_0000;
    stat_d[RXSW_OWN_BIT] = 1'b1;
    stat_d[RXSW_FS_BIT]  = fs_q;
    stat_d[RXSW_VLAN_BIT] = info_q.vlan & ls_q;
    if (ls_q) begin
      stat_d[RXSW_LS_BIT]  = 1'b1;
      stat_d[29:16]        = flen_q;
      stat_d[RXSW_ES_BIT]  = es_bit;
      stat_d[RXSW_OE_BIT]  = info_q.overflow;
      stat_d[RXSW_MP_BIT]  = mp_bit;
      stat_d[RXSW_LC_BIT]  = info_q.late_col & ctrl_q[RXSW_CTRL_HDX_BIT];
      stat_d[RXSW_FT_BIT]  = ft_bit;
      stat_d[RXSW_RWT_BIT] = rwt_q;
      stat_d[RXSW_RE_BIT]  = re_q;
      stat_d[RXSW_CE_BIT]  = info_q.crc_err;
    end
  end

  // ****************************************************
  // Main sequencer
  // ****************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= RXSW_IDLE;
      desc_ready_q <= 1'b0;
      rx_ready_q   <= 1'b0;
      room_q       <= 14'h0000;
      ls_q         <= 1'b0;
      ts_hi_q      <= 1'b0;
    end else begin
      unique case (state_q)
        RXSW_IDLE: begin
          ls_q <= 1'b0;
          if (rx_valid_i) begin
            state_q      <= RXSW_FETCH;
            desc_ready_q <= 1'b1;
          end
        end
        RXSW_FETCH: begin
          if (desc_valid_i) begin
            desc_ready_q <= 1'b0;
            room_q       <= cap;
            if (cap == 14'h0000) begin
              state_q <= RXSW_WB_STAT;
            end else begin
              state_q    <= RXSW_RECV;
              rx_ready_q <= 1'b1;
            end
          end
        end
        RXSW_RECV: begin
          if (take) room_q <= room_q - 14'd1;
          if (fin | full) begin
            rx_ready_q <= 1'b0;
            ls_q       <= fin;
            ts_hi_q    <= 1'b0;
            if (fin & ctrl_q[RXSW_CTRL_TS_BIT] & rx_info_i.ts_valid & ~wdog_hit) begin
              state_q <= RXSW_WB_TS;
            end else begin
              state_q <= RXSW_WB_STAT;
            end
          end
        end
        RXSW_WB_TS: begin
          if (wb_ready_i & wb_valid_q) begin
            ts_hi_q <= 1'b1;
            if (ts_hi_q) state_q <= RXSW_WB_STAT;
          end
        end
        RXSW_WB_STAT: begin
          if (wb_ready_i & wb_valid_q) state_q <= RXSW_WB_OWN;
        end
        RXSW_WB_OWN: begin
          if (wb_ready_i & wb_valid_q) begin
            if (ls_q & rwt_q & in_frame_q) begin
              state_q    <= RXSW_DROP;
              rx_ready_q <= 1'b1;
            end else if (ls_q | ~in_frame_q) begin
              state_q <= in_frame_q ? RXSW_FETCH : RXSW_IDLE;
              desc_ready_q <= in_frame_q;
            end else begin
              state_q      <= RXSW_FETCH;
              desc_ready_q <= 1'b1;
            end
            ls_q <= 1'b0;
          end
        end
        RXSW_DROP: begin
          // Remainder of a truncated frame is discarded
          if (rx_valid_i & rx_ready_q & rx_beat_i.last) begin
            rx_ready_q <= 1'b0;
            state_q    <= RXSW_IDLE;
          end
        end
        default: state_q <= RXSW_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Per-frame accumulation
  // ****************************************************
  // Frame bookkeeping; a truncated frame stays open until its tail is dropped
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_frame_q <= 1'b0;
      fs_q       <= 1'b0;
      flen_q     <= 14'h0000;
      re_q       <= 1'b0;
      rwt_q      <= 1'b0;
      lt_q       <= 16'h0000;
    end else if (state_q == RXSW_IDLE) begin
      in_frame_q <= 1'b0;
      fs_q       <= 1'b0;
      flen_q     <= 14'h0000;
      re_q       <= 1'b0;
      rwt_q      <= 1'b0;
      lt_q       <= 16'h0000;
    end else if (state_q == RXSW_RECV && take) begin
      if (!in_frame_q) fs_q <= 1'b1;
      in_frame_q <= ~fin | (wdog_hit & ~rx_beat_i.last);
      flen_q     <= flen_q + 14'd1;
      if (rx_er_i & rx_dv_i) re_q <= 1'b1;
      if (wdog_hit & ~rx_beat_i.last) rwt_q <= 1'b1;
      if (flen_q == RXSW_LT_HI_IDX) lt_q[15:8] <= rx_beat_i.data;
      if (flen_q == RXSW_LT_LO_IDX) lt_q[7:0] <= rx_beat_i.data;
    end else if (state_q == RXSW_RECV && rx_er_i && rx_dv_i && in_frame_q) begin
      re_q <= 1'b1;
    end else if (state_q == RXSW_WB_OWN && wb_ready_i && wb_valid_q) begin
      // First-segment mark belongs to one descriptor only
      fs_q <= 1'b0;
      if (ls_q && !rwt_q) in_frame_q <= 1'b0;
    end
  end

  // Frame-end sideband captured with the closing beat
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      info_q <= '0;
    end else if (state_q == RXSW_IDLE) begin
      info_q <= '0;
    end else if (state_q == RXSW_RECV && fin) begin
      info_q <= rx_info_i;
      if (wdog_hit & ~rx_beat_i.last) begin
        info_q.ts_valid <= 1'b0;
        info_q.crc_err  <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Write-back port
  // ****************************************************
  // Status lands with owner still set; a second write hands it to the host
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_valid_q <= 1'b0;
      wb_q       <= '0;
      stat_q     <= 32'h0000_0000;
      last_q     <= 32'h0000_0000;
      frames_q   <= 16'h0000;
    end else if (wb_valid_q && !wb_ready_i) begin
      wb_valid_q <= 1'b1; // Held until the memory side takes it
    end else begin
      wb_valid_q <= 1'b0;
      unique case (state_q)
        RXSW_WB_TS: begin
          if (!wb_valid_q || !ts_hi_q) begin
            wb_valid_q <= 1'b1;
            wb_q.word  <= (wb_valid_q | ts_hi_q) ? RXSW_WORD_TS_HI : RXSW_WORD_TS_LO;
            wb_q.data  <= (wb_valid_q | ts_hi_q) ? info_q.ts[63:32] : info_q.ts[31:0];
          end
        end
        RXSW_WB_STAT: begin
          if (!wb_valid_q) begin
            wb_valid_q <= 1'b1;
            wb_q.word  <= RXSW_WORD_STATUS;
            wb_q.data  <= stat_d;
            stat_q     <= stat_d;
          end
        end
        RXSW_WB_OWN: begin
          if (!wb_valid_q) begin
            wb_valid_q <= 1'b1;
            wb_q.word  <= RXSW_WORD_STATUS;
            wb_q.data  <= {1'b0, stat_q[30:0]};
            last_q     <= {1'b0, stat_q[30:0]};
            if (stat_q[RXSW_LS_BIT]) frames_q <= frames_q + 16'd1;
          end
        end
        default: wb_valid_q <= 1'b0;
      endcase
    end
  end

  assign prdata_o     = prdata_q;
  assign pready_o     = pready_q;
  assign pslverr_o    = pslverr_q;
  assign desc_ready_o = desc_ready_q;
  assign rx_ready_o   = rx_ready_q;
  assign wb_valid_o   = wb_valid_q;
  assign wb_o         = wb_q;

endmodule

/* File: verification/rxsw_engine_props.sv */
// Port checker for the receive status write-back engine
`timescale 1ns/1ps
module rxsw_engine_props
  import rxsw_pkg::*;
(
  input wire logic                 ref_clk_i,
  input wire logic                 rst_i,
  input wire logic                 rx_valid_i,
  input wire rxsw_pkg::rxsw_beat_t rx_beat_i,
  input wire logic                 rx_dv_i,
  input wire logic                 rx_er_i,
  input wire logic                 rx_ready_o,
  input wire logic                 wb_valid_o,
  input wire rxsw_pkg::rxsw_wb_t   wb_o,
  input wire logic                 wb_ready_i
);
  // ****************************************************
  // Helper state
  // ****************************************************
  logic        fs_pend_q;
  logic        took_q;
  logic        er_q;
  logic        st_acc;
  logic        own_clr;
  logic [31:0] d;

  // Accepted status words
  assign d       = wb_o.data;
  assign st_acc  = wb_valid_o && wb_ready_i && wb_o.word == RXSW_WORD_STATUS;
  assign own_clr = st_acc && !d[RXSW_OWN_BIT];

  // Frame start stays pending past descriptors that took no bytes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_pend_q <= 1'b1;
    end else if (own_clr) begin
      fs_pend_q <= d[RXSW_LS_BIT] || !took_q;
    end
  end

  // Bytes landed in the open descriptor
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      took_q <= 1'b0;
    end else begin
      took_q <= !own_clr && (took_q || (rx_valid_i && rx_ready_o));
    end
  end

  // Receive error seen inside the current frame
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      er_q <= 1'b0;
    end else begin
      er_q <= !(own_clr && d[RXSW_LS_BIT])
              && (er_q || (rx_valid_i && rx_ready_o && rx_dv_i && rx_er_i));
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Gap of one idle cycle, then the next word is offered
  sequence s_next(logic [2:0] w);
    !wb_valid_o ##1 (wb_valid_o && wb_o.word == w);
  endsequence

  wb_hold_a: assert property (
    wb_valid_o && !wb_ready_i |=> wb_valid_o && $stable(wb_o))
    else $error("write-back changed before acceptance");
  own_clear_a: assert property (
    st_acc && d[RXSW_OWN_BIT] |=> s_next(RXSW_WORD_STATUS)
    ##0 (!d[RXSW_OWN_BIT] && d[30:0] == $past(d[30:0], 2)))
    else $error("owner release not a copy of the status word");
  es_sum_a: assert property (
    wb_valid_o && wb_o.word == RXSW_WORD_STATUS && d[RXSW_LS_BIT] && (d[RXSW_CE_BIT]
    || d[RXSW_RE_BIT] || d[RXSW_RWT_BIT] || d[RXSW_LC_BIT] || d[RXSW_OE_BIT]) |-> d[RXSW_ES_BIT])
    else $error("error summary missing");
  es_last_a: assert property (
    wb_valid_o && wb_o.word == RXSW_WORD_STATUS && !d[RXSW_LS_BIT] |-> !d[RXSW_ES_BIT])
    else $error("error summary outside last descriptor");
  ts_pair_a: assert property (
    wb_valid_o && wb_ready_i && wb_o.word == RXSW_WORD_TS_LO
    |=> wb_valid_o && wb_o.word == RXSW_WORD_TS_HI)
    else $error("timestamp high word not next");
  ts_last_a: assert property (
    wb_valid_o && wb_ready_i && wb_o.word == RXSW_WORD_TS_HI |=> s_next(RXSW_WORD_STATUS)
    ##0 (d[RXSW_LS_BIT] && d[RXSW_MP_BIT]))
    else $error("timestamp not followed by last status");
  last_beat_a: assert property (
    rx_valid_i && rx_ready_o && rx_beat_i.last |=> !rx_ready_o)
    else $error("stream still open after last beat");
  fs_track_a: assert property (
    st_acc && d[RXSW_OWN_BIT] |-> d[RXSW_FS_BIT] == (fs_pend_q && took_q))
    else $error("first segment flag wrong");
  re_seen_a: assert property (
    st_acc && d[RXSW_LS_BIT] && er_q |-> d[RXSW_RE_BIT])
    else $error("receive error flag missing");
endmodule

bind rxsw_engine rxsw_engine_props u_props (.ref_clk_i, .rst_i, .rx_valid_i, .rx_beat_i,
  .rx_dv_i, .rx_er_i, .rx_ready_o, .wb_valid_o, .wb_o, .wb_ready_i);

/* File: verification/rxsw_host_mem.sv */
// Host memory and descriptor-owning software model
`timescale 1ns/1ps
module rxsw_host_mem
  import rxsw_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire logic               slow_i,
  input  wire logic               desc_ready_i,
  output logic                    desc_valid_o,
  output rxsw_pkg::rxsw_desc_t    desc_o,
  input  wire logic               wb_valid_i,
  input  wire rxsw_pkg::rxsw_wb_t wb_i,
  output logic                    wb_ready_o
);
  // ****************************************************
  // Host side state
  // ****************************************************
  rxsw_desc_t  dq[$];
  logic [31:0] st_q[$];
  logic [31:0] ts_q[$];

  // Descriptors in ring order; with none owned the lines carry junk
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      desc_valid_o <= 1'b0;
      desc_o       <= '0;
    end else begin
      if (desc_valid_o && desc_ready_i) begin
        void'(dq.pop_front());
      end
      desc_valid_o <= dq.size() > 0;
      desc_o       <= dq.size() > 0 ? dq[0] : ~desc_o;
    end
  end

  // Slow memory takes every other cycle; released words return to software
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ready_o <= 1'b0;
    end else begin
      wb_ready_o <= slow_i ? !wb_ready_o : 1'b1;
      if (wb_valid_i && wb_ready_o && wb_i.word != RXSW_WORD_STATUS) begin
        ts_q.push_back(wb_i.data);
      end else if (wb_valid_i && wb_ready_o && !wb_i.data[RXSW_OWN_BIT]) begin
        st_q.push_back(wb_i.data);
      end
    end
  end
endmodule

/* File: verification/tb_rx_descriptor_status_writeback.sv */
// Self-checking bench for the receive status write-back engine
`timescale 1ns/1ps
module tb_rx_descriptor_status_writeback
  import rxsw_pkg::*;
;
  // ****************************************************
  // Signals and vectors
  // ****************************************************
  localparam logic [63:0] TS = 64'h0123_4567_89ab_cdef;
  typedef struct {
    int          len;
    logic [15:0] lt;
    logic [31:0] ctrl;
    logic [4:0]  info;
    logic        er;
    logic [8:0]  exp;
  } rxsw_row_t;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, f0;
  logic        desc_valid, desc_ready, rx_valid, rx_dv, rx_er, rx_ready, wb_valid, wb_ready;
  rxsw_desc_t  desc;
  rxsw_beat_t  rx_beat;
  rxsw_info_t  rx_info;
  rxsw_wb_t    wb;
  int          n_mismatch, checked;
  // Info bits: overflow, vlan, late collision, ipv4, checksum error
  rxsw_row_t   rows[15] = '{
    '{64, 16'h0600, 0, 5'h00, 0, 9'b001100100},
    '{64, 16'h05ff, 0, 5'h00, 0, 9'b001100000},
    '{10, 16'h0600, 0, 5'h00, 0, 9'b001100000},
    '{64, 16'h0800, 0, 5'h10, 0, 9'b101100100},
    '{64, 16'h0800, 0, 5'h08, 0, 9'b011100100},
    '{64, 16'h0800, 8, 5'h04, 0, 9'b001101100},
    '{64, 16'h0800, 0, 5'h00, 1, 9'b001100101},
    '{1518, 16'h0800, 0, 5'h00, 0, 9'b001100100},
    '{1519, 16'h0800, 0, 5'h00, 0, 9'b001110100},
    '{1523, 16'h0800, 0, 5'h08, 0, 9'b011110100},
    '{2001, 16'h0800, 32'h0800_0000, 5'h00, 0, 9'b001110100},
    '{9019, 16'h0800, 4, 5'h00, 0, 9'b001110100},
    '{64, 16'h0800, 2, 5'h03, 0, 9'b001110100},
    '{64, 16'h0800, 2, 5'h00, 0, 9'b001110100},
    '{64, 16'h0800, 2, 5'h02, 0, 9'b001100100}};

  rxsw_engine DUT (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .desc_valid_i(desc_valid), .desc_i(desc),
    .desc_ready_o(desc_ready), .rx_valid_i(rx_valid), .rx_beat_i(rx_beat),
    .rx_info_i(rx_info), .rx_dv_i(rx_dv), .rx_er_i(rx_er), .rx_ready_o(rx_ready),
    .wb_valid_o(wb_valid), .wb_o(wb), .wb_ready_i(wb_ready));
  rxsw_host_mem u_mem (.ref_clk_i(clk), .rst_i(rst), .slow_i(slow), .desc_ready_i(desc_ready),
    .desc_valid_o(desc_valid), .desc_o(desc), .wb_valid_i(wb_valid), .wb_i(wb),
    .wb_ready_o(wb_ready));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask

  task tmo();
    chk("timeout", 0, 1);
    give_verdict();
  endtask

  // APB transfer held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, dt};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    rd = pslverr ? 32'hdead_0000 | prdata : prdata;
    {psel, penable} <= 2'b00;
  endtask

  // One frame, bytes 12 and 13 carry the length/type field
  task send(input int len, input logic [15:0] lt, input logic [4:0] f, input logic e);
    int n;
    rx_info <= '{1'b0, f[4], f[2], f[3], f[1], f[0], 1'b0, 1'b1, TS};
    {rx_dv, rx_er} <= {1'b1, e};
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_beat  <= '{i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'(i), i == len - 1};
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rx_ready !== 1'b1 && n < 300);
      if (rx_ready !== 1'b1) tmo();
    end
    {rx_valid, rx_dv, rx_er} <= 3'b000;
    rx_beat <= ~rx_beat;
  endtask

  task wait_st(input int k);
    int c;
    for (c = 0; u_mem.st_q.size() < k && c < 300; c++) @(posedge clk);
    if (u_mem.st_q.size() < k) tmo();
  endtask

  task frame(input int len, input logic [4:0] f, input logic e);
    u_mem.st_q.delete();
    u_mem.dq.push_back('{13'd4000, 13'd4000, 1'b0});
    send(len, 16'h0800, f, e);
  endtask

  // Main sequence: table first, then the awkward cases
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, slow} = {1'b1, 43'h0, 1'b0};
    {rx_valid, rx_dv, rx_er, rx_beat, rx_info} = '0;
    {n_mismatch, checked} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, RXSW_WDOG_OFS, 32'h3fff);
    foreach (rows[k]) begin
      apb(1'b1, RXSW_CTRL_OFS, rows[k].ctrl);
      u_mem.st_q.delete();
      u_mem.dq.push_back('{13'd8188, 13'd8188, 1'b0});
      send(rows[k].len, rows[k].lt, rows[k].info, rows[k].er);
      wait_st(1);
      chk("status_bits", rows[k].exp, u_mem.st_q[0][11:3]);
    end
    apb(1'b0, 8'h20, 0);
    chk("unmapped", 32'hdead_0000, rd);
    slow <= 1'b1;
    apb(1'b1, RXSW_CTRL_OFS, 1);
    u_mem.st_q.delete();
    u_mem.dq.push_back('{13'd0, 13'd0, 1'b0});
    u_mem.dq.push_back('{13'd0, 13'd40, 1'b0});
    u_mem.dq.push_back('{13'd16, 13'd100, 1'b1});
    send(56, 16'h0800, 0, 0);
    wait_st(3);
    chk("seg_flags", 9'b000_100_011, {u_mem.st_q[0][9:7], u_mem.st_q[1][9:7],
      u_mem.st_q[2][9:7]});
    chk("ts_count", 2, u_mem.ts_q.size());
    chk("ts_low", TS[31:0], u_mem.ts_q[0]);
    chk("ts_high", TS[63:32], u_mem.ts_q[1]);
    apb(1'b1, RXSW_WDOG_OFS, 100);
    apb(1'b0, RXSW_FRAMES_OFS, 0);
    f0 = rd;
    frame(150, 0, 0);
    wait_st(1);
    chk("watchdog", 2'b11, {u_mem.st_q[0][8], u_mem.st_q[0][4]});
    chk("truncated", 100, u_mem.st_q[0][29:16]);
    apb(1'b0, RXSW_FRAMES_OFS, 0);
    chk("frames", f0 + 1, rd);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset_outs", 0, {pready, wb_valid, desc_ready, rx_ready});
    rst <= 1'b0;
    apb(1'b0, RXSW_CTRL_OFS, 0);
    chk("ctrl_rst", RXSW_CTRL_RST, rd);
    apb(1'b0, RXSW_WDOG_OFS, 0);
    chk("wdog_rst", {18'h0, RXSW_WDOG_RST}, rd);
    give_verdict();
  end
endmodule
